// ### verilog/circ_pkg.sv
/*
 * Constants for the interworking control register bank: register indices,
 * field positions and reset values.
 * Assumes a 16-bit host bus with word addresses, one register per index.
 */
// Functional notes
// R1 - Cell bit picks emulation or ATM; service bit
// R2 - Clock recovery bits ignored on ATM ports
// R3 - Three loopback bits plus rx/tx activates
// R4 - Emergency bit permits automatic port switchover
// R5 - Multiframe bit meaning depends on line pin
// R6 - Soft reset bit pulses reset, self clears
// R7 - Three global interface enable bits
// R8 - Dummy time stamp sent twice, first cells
// R9 - Software programs dummy stamp before enable
// R10 - Two-bit select picks one of four patterns
// R11 - Pointer parity enable else bit7 zero
// R12 - Even check bit inverts checker parity
// R13 - Destructive read only when monitoring active
// R14 - Monitoring off: processor owns external RAM
// R15 - Monitoring on: shared, queue read oldest
// R16 - Counter enable masks per port kind
// R17 - Delineation fields alpha delta coset, 7655
// R18 - Receive idle header match with mask
// R19 - Transmit idle header and payload, 6A
// R20 - Transparency bits forward looped data too
// R21 - VCI filter on emulation ports only
// R22 - Interrupt mask all ones after reset
// R23 - Clock monitor live, not latched
// R24 - Unused bits read zero, ignore writes
package circ_pkg;
	localparam int ADDR_W = 5;
	localparam int NPORT = 8;
	// ****************************************
	// Register indices
	// ****************************************
	localparam logic [4:0] IDX_PORT0 = 5'h00;
	localparam logic [4:0] IDX_DEVICE_SETUP = 5'h08;
	localparam logic [4:0] IDX_MONITOR_CONTROL = 5'h09;
	localparam logic [4:0] IDX_CELL_CNT_EN = 5'h0A;
	localparam logic [4:0] IDX_EMUL_CNT_EN = 5'h0B;
	localparam logic [4:0] IDX_PATTERN_HIGH = 5'h0C;
	localparam logic [4:0] IDX_PATTERN_LOW = 5'h0D;
	localparam logic [4:0] IDX_DELINEATION = 5'h0E;
	localparam logic [4:0] IDX_RX_IDLE = 5'h0F;
	localparam logic [4:0] IDX_TX_IDLE = 5'h10;
	localparam logic [4:0] IDX_LOOP_CONTROL = 5'h11;
	localparam logic [4:0] IDX_CELL_FILL = 5'h12;
	localparam logic [4:0] IDX_INT_MASK = 5'h13;
	localparam logic [4:0] IDX_TIMER_TWO = 5'h14;
	localparam logic [4:0] IDX_REVISION = 5'h16;
	localparam logic [4:0] IDX_CLOCK_MON = 5'h17;
	// ****************************************
	// Writable bit masks
	// ****************************************
	localparam logic [15:0] MASK_PORT = 16'h07FF;
	localparam logic [15:0] MASK_DEVICE = 16'h1FFF;
	localparam logic [15:0] MASK_MONITOR = 16'h0007;
	localparam logic [15:0] MASK_CELL_CNT = 16'h001F;
	localparam logic [15:0] MASK_LOOP = 16'h01FF;
	localparam logic [15:0] MASK_FILL = 16'h00FF;
	localparam logic [15:0] MASK_TIMER = 16'h0001;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] RST_PATTERN = 16'h0FFF;
	localparam logic [15:0] RST_DELINEATION = 16'h7655;
	localparam logic [15:0] RST_RX_IDLE = 16'h0101;
	localparam logic [15:0] RST_TX_IDLE = 16'h016A;
	localparam logic [15:0] RST_INT_MASK = 16'hFFFF;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int P_TX_MFS = 0;
	localparam int P_TX_ACT = 1;
	localparam int PORT_EMERGENCY_ENABLE = 2;
	localparam int P_RX_ACT = 3;
	localparam int P_DLP = 4;
	localparam int P_ULP = 5;
	localparam int P_SLP = 6;
	localparam int P_SRTS = 7;
	localparam int P_ACM = 8;
	localparam int P_CES = 9;
	localparam int P_ATM = 10;
	localparam int D_EVEN_PCK = 0;
	localparam int D_PTR_PRTY = 1;
	localparam int D_OVF_CNT = 2;
	localparam int D_EMG_SEL_LO = 3;
	localparam int D_STAMP_LO = 5;
	localparam int D_CRV_EN = 9;
	localparam int D_UR_EN = 10;
	localparam int D_UT_EN = 11;
	localparam int D_SW_RESET = 12;
	localparam int M_OAM_ACT = 0;
	localparam int M_DEST_READ = 1;
	localparam int M_TIMER_ONE = 2;
	localparam int L_VCI_LO = 0;
	localparam int L_VCI_FLT = 5;
	localparam int L_TDLP = 6;
	localparam int L_TULP = 7;
	localparam int L_TSLP = 8;
	localparam int V_E1T1 = 6;
	localparam int V_ITST0 = 7;
	localparam int V_ITST3 = 8;
	// Dummy stamp sent twice inside this many cells
	localparam logic [4:0] STAMP_WINDOW = 5'h10;
	localparam logic [1:0] STAMP_REPEAT = 2'h2;
endpackage : circ_pkg

// ### verilog/circ_regs.sv
/*
 * Control and status register bank of the interworking device, plus the
 * decoded per-port and device-wide controls for the datapath.
 * Assumes a synchronous host strobe interface and datapath event pulses.
 */
module circ_regs #(
	parameter logic [5:0] VERSION_CODE = 6'h15, // Arbitrary value
	parameter int NPORT = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic host_cs,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [4:0] host_addr,
	input wire logic [15:0] host_wdata,
	output logic [15:0] host_rdata,
	input wire logic pin_e1_t1,
	input wire logic pin_itst0,
	input wire logic pin_itst3,
	input wire logic [7:0] rx_clock_failure,
	input wire logic segmentation_start,
	input wire logic cell_sent,
	input wire logic cell_has_stamp,
	input wire logic oam_counter_read,
	input wire logic queue_read,
	output logic soft_reset_pulse,
	output logic [7:0] port_atm,
	output logic [7:0] port_unstructured,
	output logic [7:0] port_adaptive_en,
	output logic [7:0] port_srts_en,
	output logic [7:0] port_serial_loop,
	output logic [7:0] port_up_loop,
	output logic [7:0] port_down_loop,
	output logic [7:0] port_rx_active,
	output logic [7:0] port_tx_active,
	output logic [7:0] port_emergency_enable,
	output logic [7:0] port_crc_or_esf,
	output logic [7:0] port_vci_filter_en,
	output logic cell_tx_enable,
	output logic cell_rx_enable,
	output logic clock_rec_enable,
	output logic [3:0] stamp_value,
	output logic stamp_insert,
	output logic [7:0] emergency_pattern,
	output logic pointer_parity_en,
	output logic parity_expect_inverted,
	output logic overflow_count_en,
	output logic oam_clear_on_read,
	output logic ram_cpu_only,
	output logic queue_pop_oldest,
	output logic timer_group_one_enable,
	output logic timer_group_two_enable,
	output logic [4:0] cell_counter_en,
	output logic [15:0] emul_counter_en,
	output logic [3:0] hec_alpha,
	output logic [3:0] hec_delta,
	output logic [7:0] hec_coset,
	output logic [15:0] rx_idle_match,
	output logic [7:0] tx_idle_header,
	output logic [7:0] tx_idle_payload,
	output logic serial_transparent,
	output logic up_transparent,
	output logic down_transparent,
	output logic [4:0] vci_loop_value,
	output logic [7:0] fill_octet,
	output logic [15:0] interrupt_mask_reg
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [NPORT-1:0][15:0] port_setup;
		logic [15:0] device_setup;
		logic [15:0] monitor_control;
		logic [15:0] cell_cnt;
		logic [15:0] emul_cnt;
		logic [15:0] pattern_high;
		logic [15:0] pattern_low;
		logic [15:0] delineation;
		logic [15:0] rx_idle;
		logic [15:0] tx_idle;
		logic [15:0] loop_ctl;
		logic [15:0] fill;
		logic [15:0] int_mask;
		logic [15:0] timer_two;
		logic [15:0] rdata;
		logic reset_pulse;
		logic [4:0] cells;
		logic [1:0] stamps;
		logic stamp_active;
	} circ_state_t;

	circ_state_t s_q;
	circ_state_t s_d;
	logic [15:0] revision;

	function automatic logic [15:0] circ_merge(input logic [15:0] old, input logic [15:0] wd,
		input logic [15:0] mask);
		circ_merge = (old & ~mask) | (wd & mask); // see R24
	endfunction : circ_merge

	assign revision = {7'h00, pin_itst3, pin_itst0, pin_e1_t1, VERSION_CODE};

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic wr;
		logic [15:0] rd;
		wr = host_cs && host_wr;
		rd = 16'h0000;
		s_d = s_q;
		s_d.reset_pulse = 1'b0;
		if (wr) begin
			if (host_addr[4:3] == 2'h0) begin
				s_d.port_setup[host_addr[2:0]] = circ_merge(16'h0000, host_wdata, circ_pkg::MASK_PORT);
			end
			unique case (host_addr)
				circ_pkg::IDX_DEVICE_SETUP: begin
					s_d.device_setup = circ_merge(16'h0000, host_wdata, circ_pkg::MASK_DEVICE);
				end
				circ_pkg::IDX_MONITOR_CONTROL: begin
					s_d.monitor_control = circ_merge(16'h0000, host_wdata, circ_pkg::MASK_MONITOR);
				end
				circ_pkg::IDX_CELL_CNT_EN: begin
					s_d.cell_cnt = circ_merge(16'h0000, host_wdata, circ_pkg::MASK_CELL_CNT);
				end
				circ_pkg::IDX_EMUL_CNT_EN: s_d.emul_cnt = host_wdata;
				circ_pkg::IDX_PATTERN_HIGH: s_d.pattern_high = host_wdata;
				circ_pkg::IDX_PATTERN_LOW: s_d.pattern_low = host_wdata;
				circ_pkg::IDX_DELINEATION: s_d.delineation = host_wdata;
				circ_pkg::IDX_RX_IDLE: s_d.rx_idle = host_wdata;
				circ_pkg::IDX_TX_IDLE: s_d.tx_idle = host_wdata;
				circ_pkg::IDX_LOOP_CONTROL: begin
					s_d.loop_ctl = circ_merge(16'h0000, host_wdata, circ_pkg::MASK_LOOP);
				end
				circ_pkg::IDX_CELL_FILL: begin
					s_d.fill = circ_merge(16'h0000, host_wdata, circ_pkg::MASK_FILL);
				end
				circ_pkg::IDX_INT_MASK: s_d.int_mask = host_wdata;
				circ_pkg::IDX_TIMER_TWO: begin
					s_d.timer_two = circ_merge(16'h0000, host_wdata, circ_pkg::MASK_TIMER);
				end
				default: begin
				end
			endcase
		end
		// Soft reset bit fires one internal pulse and is cleared on the same edge
		if (s_q.device_setup[circ_pkg::D_SW_RESET]) begin
			s_d.reset_pulse = 1'b1; // see R6
			s_d.device_setup[circ_pkg::D_SW_RESET] = 1'b0; // see R6
		end
		// Dummy stamp tracking after segmentation start
		if (segmentation_start) begin
			s_d.cells = 5'h00; // see R8
			s_d.stamps = 2'h0;
			s_d.stamp_active = s_q.device_setup[circ_pkg::D_CRV_EN];
		end else if (s_q.stamp_active && cell_sent) begin
			s_d.cells = s_q.cells + 5'h01;
			if (cell_has_stamp && s_q.stamps != circ_pkg::STAMP_REPEAT) begin
				s_d.stamps = s_q.stamps + 2'h1;
			end
			if (s_q.cells + 5'h01 == circ_pkg::STAMP_WINDOW) begin
				s_d.stamp_active = 1'b0;
			end
		end
		if (host_addr[4:3] == 2'h0) begin
			rd = s_q.port_setup[host_addr[2:0]];
		end else begin
			unique case (host_addr)
				circ_pkg::IDX_DEVICE_SETUP: rd = s_q.device_setup;
				circ_pkg::IDX_MONITOR_CONTROL: rd = s_q.monitor_control;
				circ_pkg::IDX_CELL_CNT_EN: rd = s_q.cell_cnt;
				circ_pkg::IDX_EMUL_CNT_EN: rd = s_q.emul_cnt;
				circ_pkg::IDX_PATTERN_HIGH: rd = s_q.pattern_high;
				circ_pkg::IDX_PATTERN_LOW: rd = s_q.pattern_low;
				circ_pkg::IDX_DELINEATION: rd = s_q.delineation;
				circ_pkg::IDX_RX_IDLE: rd = s_q.rx_idle;
				circ_pkg::IDX_TX_IDLE: rd = s_q.tx_idle;
				circ_pkg::IDX_LOOP_CONTROL: rd = s_q.loop_ctl;
				circ_pkg::IDX_CELL_FILL: rd = s_q.fill;
				circ_pkg::IDX_INT_MASK: rd = s_q.int_mask;
				circ_pkg::IDX_TIMER_TWO: rd = s_q.timer_two;
				circ_pkg::IDX_REVISION: rd = revision;
				circ_pkg::IDX_CLOCK_MON: rd = {8'h00, rx_clock_failure}; // see R23
				default: rd = 16'h0000; // see R24
			endcase
		end
		s_d.rdata = (host_cs && host_rd) ? rd : s_q.rdata;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.pattern_high <= circ_pkg::RST_PATTERN;
			s_q.pattern_low <= circ_pkg::RST_PATTERN;
			s_q.delineation <= circ_pkg::RST_DELINEATION; // see R17
			s_q.rx_idle <= circ_pkg::RST_RX_IDLE;
			s_q.tx_idle <= circ_pkg::RST_TX_IDLE; // see R19
			s_q.int_mask <= circ_pkg::RST_INT_MASK; // see R22
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Decoded controls
	// ****************************************
	always_comb begin
		for (int i = 0; i < NPORT; i++) begin
			logic atm;
			atm = s_q.port_setup[i][circ_pkg::P_ATM];
			port_atm[i] = atm; // see R1
			port_unstructured[i] = !atm && s_q.port_setup[i][circ_pkg::P_CES]; // see R1
			port_adaptive_en[i] = !atm && s_q.port_setup[i][circ_pkg::P_ACM]; // see R2
			port_srts_en[i] = !atm && s_q.port_setup[i][circ_pkg::P_SRTS]; // see R2
			port_serial_loop[i] = s_q.port_setup[i][circ_pkg::P_SLP]; // see R3
			port_up_loop[i] = s_q.port_setup[i][circ_pkg::P_ULP];
			port_down_loop[i] = s_q.port_setup[i][circ_pkg::P_DLP];
			port_rx_active[i] = s_q.port_setup[i][circ_pkg::P_RX_ACT];
			port_tx_active[i] = s_q.port_setup[i][circ_pkg::P_TX_ACT];
			port_emergency_enable[i] = s_q.port_setup[i][circ_pkg::PORT_EMERGENCY_ENABLE]; // see R4
			// Same bit: CRC multiframe on E1, ESF on T1
			port_crc_or_esf[i] = s_q.port_setup[i][circ_pkg::P_TX_MFS]; // see R5
			port_vci_filter_en[i] = !atm && s_q.loop_ctl[circ_pkg::L_VCI_FLT]; // see R21
		end
	end

	always_comb begin
		unique case (s_q.device_setup[circ_pkg::D_EMG_SEL_LO +: 2])
			2'h0: emergency_pattern = s_q.pattern_low[7:0]; // see R10
			2'h1: emergency_pattern = s_q.pattern_low[15:8];
			2'h2: emergency_pattern = s_q.pattern_high[7:0];
			2'h3: emergency_pattern = s_q.pattern_high[15:8];
		endcase
	end

	assign host_rdata = s_q.rdata;
	assign soft_reset_pulse = s_q.reset_pulse;
	assign cell_tx_enable = s_q.device_setup[circ_pkg::D_UT_EN]; // see R7
	assign cell_rx_enable = s_q.device_setup[circ_pkg::D_UR_EN];
	assign clock_rec_enable = s_q.device_setup[circ_pkg::D_CRV_EN];
	// Unprogrammed stamp goes out as zero; that is software's duty
	assign stamp_value = s_q.device_setup[circ_pkg::D_STAMP_LO +: 4]; // see R9
	assign stamp_insert = s_q.stamp_active && s_q.stamps != circ_pkg::STAMP_REPEAT; // see R8
	assign pointer_parity_en = s_q.device_setup[circ_pkg::D_PTR_PRTY]; // see R11
	assign parity_expect_inverted = s_q.device_setup[circ_pkg::D_EVEN_PCK]; // see R12
	assign overflow_count_en = s_q.device_setup[circ_pkg::D_OVF_CNT];
	assign oam_clear_on_read = oam_counter_read && s_q.monitor_control[circ_pkg::M_OAM_ACT]
		&& s_q.monitor_control[circ_pkg::M_DEST_READ]; // see R13
	assign ram_cpu_only = !s_q.monitor_control[circ_pkg::M_OAM_ACT]; // see R14
	assign queue_pop_oldest = queue_read && s_q.monitor_control[circ_pkg::M_OAM_ACT]; // see R15
	assign timer_group_one_enable = s_q.monitor_control[circ_pkg::M_TIMER_ONE];
	assign timer_group_two_enable = s_q.timer_two[0];
	assign cell_counter_en = s_q.cell_cnt[4:0]; // see R16
	assign emul_counter_en = s_q.emul_cnt;
	assign hec_alpha = s_q.delineation[15:12];
	assign hec_delta = s_q.delineation[11:8];
	assign hec_coset = s_q.delineation[7:0];
	assign rx_idle_match = s_q.rx_idle; // see R18
	assign tx_idle_header = s_q.tx_idle[15:8];
	assign tx_idle_payload = s_q.tx_idle[7:0];
	assign serial_transparent = s_q.loop_ctl[circ_pkg::L_TSLP]; // see R20
	assign up_transparent = s_q.loop_ctl[circ_pkg::L_TULP];
	assign down_transparent = s_q.loop_ctl[circ_pkg::L_TDLP];
	assign vci_loop_value = s_q.loop_ctl[circ_pkg::L_VCI_LO +: 5];
	assign fill_octet = s_q.fill[7:0];
	assign interrupt_mask_reg = s_q.int_mask;
endmodule : circ_regs

// ### verif/circ_regs_props.sv
/* Checker for the control register bank, bound to circ_regs.
   Assumes one clock and synchronous active-low reset at the ports. */
module circ_regs_props (
	input wire logic clk,
	input wire logic rstn,
	input wire logic host_cs,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [4:0] host_addr,
	input wire logic [15:0] host_wdata,
	input wire logic [15:0] host_rdata,
	input wire logic [7:0] rx_clock_failure,
	input wire logic oam_counter_read,
	input wire logic queue_read,
	input wire logic soft_reset_pulse,
	input wire logic [7:0] port_atm,
	input wire logic [7:0] port_unstructured,
	input wire logic [7:0] port_adaptive_en,
	input wire logic [7:0] port_srts_en,
	input wire logic [7:0] port_vci_filter_en,
	input wire logic oam_clear_on_read,
	input wire logic ram_cpu_only,
	input wire logic queue_pop_oldest,
	input wire logic [15:0] interrupt_mask_reg
);
	wire logic rd_ev = host_cs && host_rd;
	wire logic wr_ev = host_cs && host_wr;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// ****************************************
	// Properties
	// ****************************************
	srst_pulse_a: assert property (wr_ev && host_addr == 5'h08 && host_wdata[12]
		|-> ##[1:3] soft_reset_pulse) else $error("soft reset pulse missing");
	srst_once_a: assert property (soft_reset_pulse |=> !soft_reset_pulse)
		else $error("soft reset pulse too long");
	atm_gate_a: assert property ((port_atm & (port_unstructured | port_adaptive_en
		| port_srts_en | port_vci_filter_en)) == 8'h00) else $error("emulation bit on cell port");
	clk_live_a: assert property (rd_ev && host_addr == 5'h17
		|=> host_rdata == {8'h00, $past(rx_clock_failure)}) else $error("clock monitor stale");
	unused_rd_a: assert property (rd_ev && (host_addr == 5'h15 || host_addr[4:3] == 2'h3)
		|=> host_rdata == 16'h0000) else $error("unused index not zero");
	vers_pad_a: assert property (rd_ev && host_addr == 5'h16
		|=> host_rdata[15:9] == 7'h00) else $error("revision upper bits not zero");
	dest_gate_a: assert property (oam_clear_on_read |-> oam_counter_read && !ram_cpu_only)
		else $error("clear on read while monitoring off");
	pop_gate_a: assert property (queue_pop_oldest == (queue_read && !ram_cpu_only))
		else $error("queue pop gating wrong");
	mask_wr_a: assert property (wr_ev && host_addr == 5'h13
		|=> interrupt_mask_reg == $past(host_wdata)) else $error("mask write lost");
endmodule : circ_regs_props

bind circ_regs circ_regs_props chk (.clk, .rstn, .host_cs, .host_wr, .host_rd, .host_addr,
	.host_wdata, .host_rdata, .rx_clock_failure, .oam_counter_read, .queue_read,
	.soft_reset_pulse, .port_atm, .port_unstructured, .port_adaptive_en, .port_srts_en,
	.port_vci_filter_en, .oam_clear_on_read, .ram_cpu_only, .queue_pop_oldest,
	.interrupt_mask_reg);

// ### verif/circ_host.sv
/* Host processor model driving the register strobes.
   Assumes requests are taken at the rising edge after they are set up. */
module circ_host (
	input wire logic clk,
	output logic cs,
	output logic wr,
	output logic rd,
	output logic [4:0] addr,
	output logic [15:0] wdata,
	input wire logic [15:0] rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cs = 1'h0;
		wr = 1'h0;
		rd = 1'h0;
		addr = 5'h00;
		wdata = 16'h0000;
	end
	// ****************************************
	// Bus cycles
	// ****************************************
	// Released address and data lines are inverted so stale values never pass for valid
	task automatic put(input logic [4:0] a, input logic [15:0] d, input logic w);
		@(posedge clk);
		cs <= 1'h1;
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		cs <= 1'h0;
		wr <= 1'h0;
		rd <= 1'h0;
		addr <= ~a;
		wdata <= ~d;
	endtask : put
	task automatic get(input logic [4:0] a, output logic [15:0] d);
		put(a, 16'h0000, 1'h0);
		@(posedge clk);
		d = rdata;
	endtask : get
endmodule : circ_host

// ### verif/cell_interworking_control_regs_bench.sv
/* Self-checking bench for the control register bank.
   Assumes circ_host drives the strobes and the checker is bound to the design. */
module cell_interworking_control_regs_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [5:0] VER = 6'h2A; // Arbitrary value
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic host_cs, host_wr, host_rd;
	logic [4:0] host_addr;
	logic [15:0] host_wdata, host_rdata, rv;
	logic pin_e1_t1 = 1'h1, pin_itst0 = 1'h1, pin_itst3 = 1'h0;
	logic [7:0] rx_clock_failure = 8'h00;
	logic segmentation_start = 1'h0, cell_sent = 1'h0, cell_has_stamp = 1'h0;
	logic oam_counter_read = 1'h0, queue_read = 1'h0;
	logic soft_reset_pulse, cell_tx_enable, cell_rx_enable, clock_rec_enable, stamp_insert;
	logic oam_clear_on_read, ram_cpu_only, queue_pop_oldest;
	logic [3:0] stamp_value;
	logic [7:0] emergency_pattern, port_adaptive_en, port_srts_en, port_unstructured;
	logic [7:0] port_atm, port_serial_loop, port_up_loop, port_down_loop, port_rx_active;
	logic [7:0] port_tx_active, port_emergency_enable, port_crc_or_esf, port_vci_filter_en;
	logic pointer_parity_en, parity_expect_inverted, overflow_count_en, serial_transparent;
	logic up_transparent, down_transparent, timer_group_one_enable, timer_group_two_enable;
	logic [4:0] cell_counter_en, vci_loop_value;
	logic [3:0] hec_alpha, hec_delta;
	logic [7:0] hec_coset, tx_idle_header, tx_idle_payload, fill_octet;
	logic [15:0] emul_counter_en, rx_idle_match, interrupt_mask_reg;
	int fail_count = 0, n_checks = 0, cyc = 0, pulses = 0;
	always #50 clk = ~clk;
	circ_regs #(.VERSION_CODE(VER), .NPORT(8)) dut (
		.clk, .rstn, .host_cs, .host_wr, .host_rd, .host_addr, .host_wdata, .host_rdata,
		.pin_e1_t1, .pin_itst0, .pin_itst3, .rx_clock_failure, .segmentation_start,
		.cell_sent, .cell_has_stamp, .oam_counter_read, .queue_read, .soft_reset_pulse,
		.port_atm, .port_unstructured, .port_adaptive_en, .port_srts_en,
		.port_serial_loop, .port_up_loop, .port_down_loop, .port_rx_active,
		.port_tx_active, .port_emergency_enable, .port_crc_or_esf,
		.port_vci_filter_en, .cell_tx_enable, .cell_rx_enable, .clock_rec_enable,
		.stamp_value, .stamp_insert, .emergency_pattern, .pointer_parity_en,
		.parity_expect_inverted, .overflow_count_en, .oam_clear_on_read, .ram_cpu_only,
		.queue_pop_oldest, .timer_group_one_enable, .timer_group_two_enable,
		.cell_counter_en, .emul_counter_en, .hec_alpha, .hec_delta, .hec_coset,
		.rx_idle_match, .tx_idle_header, .tx_idle_payload, .serial_transparent,
		.up_transparent, .down_transparent, .vci_loop_value, .fill_octet,
		.interrupt_mask_reg
	);
	circ_host host (.clk, .cs(host_cs), .wr(host_wr), .rd(host_rd), .addr(host_addr),
		.wdata(host_wdata), .rdata(host_rdata));
	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
		host.get(a, rv);
		check("register", rv, exp);
	endtask : rchk
	function automatic logic [15:0] rst_val(input logic [4:0] a);
		case (a)
			5'h0C, 5'h0D: return 16'h0FFF;
			5'h0E: return 16'h7655;
			5'h0F: return 16'h0101;
			5'h10: return 16'h016A;
			5'h13: return 16'hFFFF;
			5'h16: return {7'h00, pin_itst3, pin_itst0, pin_e1_t1, VER};
			default: return 16'h0000;
		endcase
	endfunction : rst_val
	// Readback after writing all ones: only the implemented bits stick
	function automatic logic [15:0] ones_val(input logic [4:0] a);
		if (a < 5'h08) return 16'h07FF;
		case (a)
			5'h08: return 16'h0FFF;
			5'h09: return 16'h0007;
			5'h0A: return 16'h001F;
			5'h11: return 16'h01FF;
			5'h12: return 16'h00FF;
			5'h14: return 16'h0001;
			default: return a < 5'h15 ? 16'hFFFF : rst_val(a);
		endcase
	endfunction : ones_val
	function automatic logic [15:0] ens();
		return 16'({cell_tx_enable, cell_rx_enable, clock_rec_enable});
	endfunction : ens
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		for (int i = 0; i < 32; i++) rchk(5'(i), rst_val(5'(i)));
		// Soft reset bit kept clear here so no soft reset pulse fires mid-table
		for (int i = 0; i < 32; i++) host.put(5'(i), i == 8 ? 16'hEFFF : 16'hFFFF, 1'h1);
		for (int i = 0; i < 32; i++) rchk(5'(i), ones_val(5'(i)));
		host.put(5'h03, 16'h03FF, 1'h1);
		@(posedge clk);
		check("port3", 16'({port_unstructured[3], port_adaptive_en[3], port_srts_en[3]}),
			16'h0007);
	endtask : t_regs
	task automatic t_srst;
		pulses = 0;
		host.put(5'h08, 16'h1000, 1'h1);
		repeat (4) @(posedge clk);
		check("pulses", 16'(pulses), 16'h0001);
		rchk(5'h08, 16'h0000);
	endtask : t_srst
	task automatic t_emg;
		host.put(5'h0D, 16'h2110, 1'h1);
		host.put(5'h0C, 16'h4332, 1'h1);
		for (int s = 0; s < 4; s++) begin
			host.put(5'h08, 16'h0E00 | 16'(s << 3), 1'h1);
			@(posedge clk);
			check("pattern", 16'(emergency_pattern), 16'h0010 + 16'(s * 8'h11));
			check("enables", ens(), 16'h0007);
		end
		host.put(5'h08, 16'h0000, 1'h1);
		@(posedge clk);
		check("enables", ens(), 16'h0000);
	endtask : t_emg
	task automatic t_stamp;
		host.put(5'h08, 16'h0140, 1'h1);
		host.put(5'h08, 16'h0340, 1'h1);
		@(posedge clk);
		check("stamp", 16'(stamp_value), 16'h000A);
		segmentation_start <= 1'h1;
		@(posedge clk);
		segmentation_start <= 1'h0;
		@(posedge clk);
		check("open", 16'(stamp_insert), 16'h0001);
		cell_sent <= 1'h1;
		cell_has_stamp <= 1'h1;
		repeat (2) @(posedge clk);
		cell_sent <= 1'h0;
		cell_has_stamp <= 1'h0;
		repeat (2) @(posedge clk);
		check("closed", 16'(stamp_insert), 16'h0000);
		// Window end point: open after 15 cells, shut by the 16th
		segmentation_start <= 1'h1;
		@(posedge clk);
		segmentation_start <= 1'h0;
		cell_sent <= 1'h1;
		repeat (15) @(posedge clk);
		cell_sent <= 1'h0;
		@(posedge clk);
		check("window", 16'(stamp_insert), 16'h0001);
		cell_sent <= 1'h1;
		@(posedge clk);
		cell_sent <= 1'h0;
		@(posedge clk);
		check("window", 16'(stamp_insert), 16'h0000);
	endtask : t_stamp
	task automatic t_mon;
		rx_clock_failure <= 8'hA5;
		rchk(5'h17, 16'h00A5);
		rx_clock_failure <= 8'h00;
		rchk(5'h17, 16'h0000);
		oam_counter_read <= 1'h1;
		queue_read <= 1'h1;
		for (int m = 0; m < 4; m++) begin
			host.put(5'h09, 16'(m), 1'h1);
			@(posedge clk);
			check("arbiter", 16'({oam_clear_on_read, queue_pop_oldest, ram_cpu_only}),
				m == 3 ? 16'h0006 : m == 1 ? 16'h0002 : 16'h0001);
		end
		oam_counter_read <= 1'h0;
		queue_read <= 1'h0;
	endtask : t_mon
	task automatic t_dec;
		check("filter", 16'(port_vci_filter_en), 16'h0008);
		host.put(5'h05, 16'h0055, 1'h1);
		@(posedge clk);
		check("filter", 16'(port_vci_filter_en), 16'h0028);
		check("port5", 16'({port_serial_loop[5], port_up_loop[5], port_down_loop[5],
			port_rx_active[5], port_tx_active[5], port_emergency_enable[5],
			port_crc_or_esf[5], port_atm[5]}), 16'h00A6);
		host.put(5'h11, 16'h0145, 1'h1);
		host.put(5'h08, 16'h0006, 1'h1);
		host.put(5'h0A, 16'h0013, 1'h1);
		host.put(5'h0B, 16'h8421, 1'h1);
		host.put(5'h0E, 16'h3C5A, 1'h1);
		host.put(5'h0F, 16'h5A0F, 1'h1);
		host.put(5'h10, 16'h0A6B, 1'h1);
		host.put(5'h12, 16'h00C3, 1'h1);
		host.put(5'h13, 16'h5AA5, 1'h1);
		host.put(5'h09, 16'h0004, 1'h1);
		host.put(5'h14, 16'h0000, 1'h1);
		@(posedge clk);
		check("loop", 16'({serial_transparent, up_transparent, down_transparent,
			vci_loop_value}), 16'h00A5);
		check("filter", 16'(port_vci_filter_en), 16'h0000);
		check("parity", 16'({overflow_count_en, pointer_parity_en, parity_expect_inverted}),
			16'h0006);
		check("counters", 16'(cell_counter_en), 16'h0013);
		check("counters", emul_counter_en, 16'h8421);
		check("delineation", 16'({hec_alpha, hec_delta, hec_coset}), 16'h3C5A);
		check("rx idle", rx_idle_match, 16'h5A0F);
		check("tx idle", 16'({tx_idle_header, tx_idle_payload}), 16'h0A6B);
		check("fill", 16'(fill_octet), 16'h00C3);
		check("mask", interrupt_mask_reg, 16'h5AA5);
		check("timers", 16'({timer_group_one_enable, timer_group_two_enable}), 16'h0002);
		// T1 line: revision shows the pin low
		pin_e1_t1 <= 1'h0;
		rchk(5'h16, 16'h00AA);
	endtask : t_dec
	// ****************************************
	// Sequence and verdict
	// ****************************************
	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : test_done
	always @(posedge clk) begin
		if (soft_reset_pulse === 1'h1) pulses++;
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			test_done();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'h1;
		t_regs();
		t_srst();
		t_emg();
		t_stamp();
		t_mon();
		t_dec();
		test_done();
	end
endmodule : cell_interworking_control_regs_bench
